// ===== core/cac_pkg.sv
// constants, types and field layout of the attribute and card configuration register block
package cac_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int IDX_W = 6;
    localparam int CTRL_PINS = 6;
    localparam int SYNC_W = CTRL_PINS + ADDR_W + DATA_W;

    localparam logic [ADDR_W-1:0] OFF_CONFIG_OPTION = 11'h0200;
    localparam logic [ADDR_W-1:0] OFF_CARD_CONFIG_STATUS = 11'h0202;
    localparam logic [ADDR_W-1:0] OFF_PIN_REPLACEMENT = 11'h0204;
    localparam logic [ADDR_W-1:0] OFF_SOCKET_COPY = 11'h0206;

    localparam int ATTR_REG_SPACE_POS = 9;
    localparam int ODD_ADDR_POS = 0;

    localparam int SOFT_RESET_POS = 7;
    localparam int LEVEL_IRQ_POS = 6;
    localparam int CHANGED_POS = 7;
    localparam int STATUS_CHG_EN_POS = 6;
    localparam int IO8_REQ_POS = 5;
    localparam int PWR_DOWN_REQ_POS = 2;
    localparam int INT_STATE_POS = 1;
    localparam int READY_CHG_POS = 5;
    localparam int PROTECT_CHG_POS = 4;
    localparam int READY_STATE_POS = 1;
    localparam int PROTECT_STATE_POS = 0;
    localparam int READY_MASK_POS = 1;
    localparam int PROTECT_MASK_POS = 0;
    localparam int DRIVE_NUM_POS = 4;

    localparam logic [BYTE_W-1:0] PIN_FIXED_ONES = 8'h0C;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic PROTECT_STATE = 1'b0;

    localparam logic [IDX_W-1:0] IDX_MEMORY = 6'h00;
    localparam logic [IDX_W-1:0] IDX_IO_ANY = 6'h01;
    localparam logic [IDX_W-1:0] IDX_IO_PRIMARY = 6'h02;
    localparam logic [IDX_W-1:0] IDX_IO_SECONDARY = 6'h03;

    localparam logic [1:0] LANES_NONE = 2'h0;
    localparam logic [1:0] LANE_LOW_ONLY = 2'h1;

    typedef enum logic [2:0] {
        ACC_NONE = 3'h0,
        ACC_COMMON = 3'h1,
        ACC_CIS = 3'h3,
        ACC_CONFIG = 3'h2,
        ACC_INVALID = 3'h6
    } cac_kind_t;

    typedef struct packed {
        cac_kind_t kind;
        logic [1:0] lanes;
    } cac_dec_t;
endpackage

// ===== core/cac_pin_if.sv
// synchronised host socket pins shared by the synchroniser, decoder and register block
`timescale 1ns/100ps
interface cac_pin_if;
    import cac_pkg::*;
    logic hw_reset;
    logic low_sel_n;
    logic high_sel_n;
    logic attr_sel_n;
    logic rd_en_n;
    logic wr_en_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    modport sync_mp (output hw_reset, low_sel_n, high_sel_n, attr_sel_n, rd_en_n, wr_en_n, addr, wdata);
    modport use_mp (input hw_reset, low_sel_n, high_sel_n, attr_sel_n, rd_en_n, wr_en_n, addr, wdata);
endinterface

// ===== core/cac_sync.sv
// two-flop synchroniser for every host socket pin
`timescale 1ns/100ps
module cac_sync (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // raw pins
    input wire logic [cac_pkg::SYNC_W-1:0] raw_pins,
    // synchronised pins
    cac_pin_if.sync_mp pins
);
    import cac_pkg::*;
    typedef struct packed {
        logic [SYNC_W-1:0] stage1;
        logic [SYNC_W-1:0] stage2;
    } cac_sync_st_t;
    cac_sync_st_t st_reg;
    cac_sync_st_t st_next;

    // idle pin levels at reset so no false strobe edge appears at release
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b0, {(CTRL_PINS-1){1'b1}}, {(ADDR_W+DATA_W){1'b0}}};

    always_comb begin
        st_next.stage1 = raw_pins;
        st_next.stage2 = st_reg.stage1;
        if (srst) begin
            st_next.stage1 = SYNC_IDLE;
            st_next.stage2 = SYNC_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign {pins.hw_reset, pins.low_sel_n, pins.high_sel_n, pins.attr_sel_n, pins.rd_en_n, pins.wr_en_n,
            pins.addr, pins.wdata} = st_reg.stage2;
endmodule

// ===== core/cac_decode.sv
// decodes socket select, space select and address lines into an access kind and byte lanes
`timescale 1ns/100ps
module cac_decode (
    // synchronised pins
    cac_pin_if.use_mp pins,
    // decoded access
    output cac_pkg::cac_dec_t dec
);
    import cac_pkg::*;
    logic lo_sel;
    logic hi_sel;

    assign lo_sel = ~pins.low_sel_n;
    assign hi_sel = ~pins.high_sel_n;

    always_comb begin
        dec.kind = ACC_NONE;
        dec.lanes = LANES_NONE;
        if (lo_sel || hi_sel) begin
            if (pins.attr_sel_n) begin
                dec.kind = ACC_COMMON;
                dec.lanes = {hi_sel, lo_sel};
            end else begin
                dec.lanes = LANE_LOW_ONLY;
                if (!lo_sel || (!hi_sel && pins.addr[ODD_ADDR_POS])) begin
                    dec.kind = ACC_INVALID;
                end else if (pins.addr[ATTR_REG_SPACE_POS]) begin
                    dec.kind = ACC_CONFIG;
                end else if (pins.rd_en_n) begin
                    dec.kind = ACC_INVALID;
                end else begin
                    dec.kind = ACC_CIS;
                end
            end
        end
    end
endmodule

// ===== core/cac_regs.sv
// card attribute decode and configuration registers behind the host socket pins
`timescale 1ns/100ps
module cac_regs #(
    parameter int IRQ_PULSE_CYC = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // host socket pins
    input wire logic hw_reset,
    input wire logic low_byte_select_n,
    input wire logic high_byte_select_n,
    input wire logic attr_select_n,
    input wire logic out_enable_n,
    input wire logic write_enable_n,
    input wire logic [cac_pkg::ADDR_W-1:0] host_addr,
    input wire logic [cac_pkg::DATA_W-1:0] host_wdata,
    output logic [cac_pkg::DATA_W-1:0] host_rdata,
    output logic [1:0] host_rdata_oe_n,
    output logic status_change_out_n,
    output logic rdy_irq_out,
    // card core status
    input wire logic ready_busy,
    input wire logic irq_request,
    input wire logic irq_disable_bit,
    input wire logic power_done,
    input wire logic cmd_received,
    input wire logic core_idle,
    input wire logic [cac_pkg::DATA_W-1:0] cm_rdata,
    input wire logic [cac_pkg::BYTE_W-1:0] cis_rdata,
    // card core control
    output logic card_reset,
    output logic power_down,
    output logic mode_memory,
    output logic mode_io_any,
    output logic mode_io_primary,
    output logic mode_io_secondary,
    output logic drive_number,
    output logic cm_read,
    output logic cm_write,
    output logic [1:0] cm_lanes,
    output logic [cac_pkg::ADDR_W-1:0] mem_addr,
    output logic [cac_pkg::DATA_W-1:0] cm_wdata,
    output logic cis_read,
    output logic invalid_access
);
    import cac_pkg::*;
    localparam int PW = $clog2(IRQ_PULSE_CYC + 1);

    typedef struct packed {
        logic wr_low_prev;
        logic [ADDR_W-1:0] cap_addr;
        logic [DATA_W-1:0] cap_data;
        cac_dec_t cap_dec;
        logic soft_reset_bit;
        logic level_irq_select;
        logic [IDX_W-1:0] config_index;
        logic status_change_enable;
        logic eight_bit_io_request;
        logic power_down_request;
        logic pwr_pending;
        logic ready_change_flag;
        logic protect_change_flag;
        logic drive_number;
        logic ready_prev;
        logic protect_prev;
        logic int_prev;
        logic [PW-1:0] pulse_cnt;
        logic [DATA_W-1:0] host_rdata;
        logic [1:0] host_rdata_oe_n;
        logic status_change_out_n;
        logic rdy_irq_out;
        logic card_reset;
        logic power_down;
        logic [3:0] mode;
        logic cm_read;
        logic cm_write;
        logic [1:0] cm_lanes;
        logic [ADDR_W-1:0] mem_addr;
        logic [DATA_W-1:0] cm_wdata;
        logic cis_read;
        logic invalid_access;
    } cac_state_t;

    cac_state_t st_reg;
    cac_state_t n;
    cac_dec_t dec;
    logic card_rst;
    logic ready_state;
    logic int_bit;
    logic changed;
    logic io_mode;
    logic rd_act;
    logic wr_low;
    logic wr_fire;
    logic [BYTE_W-1:0] wbyte;

    cac_pin_if pins_i ();

    cac_sync cac_sync_inst (
        .clk(clk),
        .srst(srst),
        .raw_pins({hw_reset, low_byte_select_n, high_byte_select_n, attr_select_n, out_enable_n,
                   write_enable_n, host_addr, host_wdata}),
        .pins(pins_i)
    );

    cac_decode cac_decode_inst (
        .pins(pins_i),
        .dec(dec)
    );

    assign card_rst = pins_i.hw_reset | st_reg.soft_reset_bit;
    // a pending power change reports busy, and so does a card held in reset
    assign ready_state = ready_busy & ~st_reg.pwr_pending & ~card_rst;
    assign int_bit = irq_request & ~irq_disable_bit;
    assign changed = st_reg.ready_change_flag | st_reg.protect_change_flag;
    assign io_mode = (st_reg.config_index == IDX_IO_ANY) || (st_reg.config_index == IDX_IO_PRIMARY)
                     || (st_reg.config_index == IDX_IO_SECONDARY);
    assign rd_act = ~pins_i.rd_en_n & pins_i.wr_en_n & (dec.kind != ACC_NONE);
    assign wr_low = ~pins_i.wr_en_n & pins_i.rd_en_n & (dec.kind != ACC_NONE);
    // data is latched at the trailing edge of the write strobe, using the last sample taken while low
    assign wr_fire = st_reg.wr_low_prev & ~wr_low;
    assign wbyte = st_reg.cap_data[BYTE_W-1:0];

    function automatic logic [BYTE_W-1:0] cfg_byte(input logic [ADDR_W-1:0] a);
        logic [BYTE_W-1:0] b;
        b = BYTE_ZERO;
        unique case (a)
            OFF_CONFIG_OPTION: begin
                b = {st_reg.soft_reset_bit, st_reg.level_irq_select, st_reg.config_index};
            end
            OFF_CARD_CONFIG_STATUS: begin
                b[CHANGED_POS] = changed;
                b[STATUS_CHG_EN_POS] = st_reg.status_change_enable;
                b[IO8_REQ_POS] = st_reg.eight_bit_io_request;
                b[PWR_DOWN_REQ_POS] = st_reg.power_down_request;
                b[INT_STATE_POS] = int_bit;
            end
            OFF_PIN_REPLACEMENT: begin
                b = PIN_FIXED_ONES;
                b[READY_CHG_POS] = st_reg.ready_change_flag;
                b[PROTECT_CHG_POS] = st_reg.protect_change_flag;
                b[READY_STATE_POS] = ready_state;
                b[PROTECT_STATE_POS] = PROTECT_STATE;
            end
            OFF_SOCKET_COPY: begin
                b[DRIVE_NUM_POS] = st_reg.drive_number;
            end
            default: begin
                b = BYTE_ZERO;
            end
        endcase
        return b;
    endfunction

    always_comb begin
        n = st_reg;
        n.wr_low_prev = wr_low;
        if (wr_low) begin
            n.cap_addr = pins_i.addr;
            n.cap_data = pins_i.wdata;
            n.cap_dec = dec;
        end
        n.cm_write = 1'b0;
        n.invalid_access = 1'b0;
        // register writes; invalid kinds touch nothing
        if (wr_fire && st_reg.cap_dec.kind == ACC_CONFIG) begin
            unique case (st_reg.cap_addr)
                OFF_CONFIG_OPTION: begin
                    n.soft_reset_bit = wbyte[SOFT_RESET_POS];
                    n.level_irq_select = wbyte[LEVEL_IRQ_POS];
                    n.config_index = wbyte[IDX_W-1:0];
                end
                OFF_CARD_CONFIG_STATUS: begin
                    n.status_change_enable = wbyte[STATUS_CHG_EN_POS];
                    n.eight_bit_io_request = wbyte[IO8_REQ_POS];
                    n.power_down_request = wbyte[PWR_DOWN_REQ_POS];
                    if (wbyte[PWR_DOWN_REQ_POS] != st_reg.power_down_request) begin
                        n.pwr_pending = 1'b1;
                    end
                end
                OFF_PIN_REPLACEMENT: begin
                    if (wbyte[READY_MASK_POS]) begin
                        n.ready_change_flag = wbyte[READY_CHG_POS];
                    end
                    if (wbyte[PROTECT_MASK_POS]) begin
                        n.protect_change_flag = wbyte[PROTECT_CHG_POS];
                    end
                end
                OFF_SOCKET_COPY: begin
                    n.drive_number = wbyte[DRIVE_NUM_POS];
                end
                default: begin
                    n.drive_number = st_reg.drive_number;
                end
            endcase
        end
        if (wr_fire && st_reg.cap_dec.kind == ACC_COMMON) begin
            n.cm_write = 1'b1;
            n.cm_lanes = st_reg.cap_dec.lanes;
            n.mem_addr = st_reg.cap_addr;
            n.cm_wdata = st_reg.cap_data;
        end
        if (wr_fire && st_reg.cap_dec.kind == ACC_INVALID) begin
            n.invalid_access = 1'b1;
        end
        // the done pulse is only honoured when no new change arrives in the same cycle
        if (power_done && !n.pwr_pending) begin
            n.pwr_pending = 1'b0;
        end else if (power_done && !(wr_fire && n.power_down_request != st_reg.power_down_request)) begin
            n.pwr_pending = 1'b0;
        end
        // state changes set the flags after the host write, so a host write never loses a set; card reset still clears them
        n.ready_prev = ready_state;
        n.protect_prev = PROTECT_STATE;
        if (ready_state != st_reg.ready_prev) begin
            n.ready_change_flag = 1'b1;
        end
        if (PROTECT_STATE != st_reg.protect_prev) begin
            n.protect_change_flag = 1'b1;
        end
        if (card_rst) begin
            n.level_irq_select = 1'b0;
            n.config_index = IDX_MEMORY;
            n.status_change_enable = 1'b0;
            n.eight_bit_io_request = 1'b0;
            n.power_down_request = 1'b0;
            n.pwr_pending = 1'b0;
            n.ready_change_flag = 1'b0;
            n.protect_change_flag = 1'b0;
            n.drive_number = 1'b0;
        end
        if (pins_i.hw_reset) begin
            n.soft_reset_bit = 1'b0;
        end
        // read path
        n.host_rdata = {DATA_W{1'b0}};
        n.host_rdata_oe_n = ~LANES_NONE;
        n.cm_read = 1'b0;
        n.cis_read = 1'b0;
        if (rd_act) begin
            n.mem_addr = pins_i.addr;
            unique case (dec.kind)
                ACC_COMMON: begin
                    n.host_rdata = cm_rdata;
                    n.host_rdata_oe_n = ~dec.lanes;
                    n.cm_read = 1'b1;
                    n.cm_lanes = dec.lanes;
                end
                ACC_CIS: begin
                    n.host_rdata = {BYTE_ZERO, cis_rdata};
                    n.host_rdata_oe_n = ~LANE_LOW_ONLY;
                    n.cis_read = 1'b1;
                end
                ACC_CONFIG: begin
                    n.host_rdata = {BYTE_ZERO, cfg_byte(pins_i.addr)};
                    n.host_rdata_oe_n = ~LANE_LOW_ONLY;
                end
                ACC_INVALID: begin
                    n.invalid_access = 1'b1;
                end
                ACC_NONE: begin
                    n.host_rdata_oe_n = ~LANES_NONE;
                end
            endcase
        end
        // interrupt and status pins; pulse width counted from the rising request
        n.int_prev = int_bit;
        if (int_bit && !st_reg.int_prev && !st_reg.level_irq_select) begin
            n.pulse_cnt = PW'(IRQ_PULSE_CYC);
        end else if (st_reg.pulse_cnt != '0) begin
            n.pulse_cnt = st_reg.pulse_cnt - PW'(1);
        end
        if (io_mode) begin
            n.rdy_irq_out = st_reg.level_irq_select ? ~int_bit : (st_reg.pulse_cnt == '0);
        end else begin
            n.rdy_irq_out = ready_state;
        end
        n.status_change_out_n = ~(io_mode & st_reg.status_change_enable & changed);
        n.card_reset = card_rst;
        // automatic idle power-down and the request each power down; a command always wakes
        n.power_down = cmd_received ? 1'b0 : (core_idle | st_reg.power_down_request);
        n.mode = {st_reg.config_index == IDX_IO_SECONDARY, st_reg.config_index == IDX_IO_PRIMARY,
                  st_reg.config_index == IDX_IO_ANY, st_reg.config_index == IDX_MEMORY};
        if (srst) begin
            n = '0;
            n.host_rdata_oe_n = ~LANES_NONE;
            n.status_change_out_n = 1'b1;
            n.card_reset = 1'b1;
            n.ready_prev = ready_state; // start at the live level so no false change follows reset
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= n;
    end

    assign host_rdata = st_reg.host_rdata;
    assign host_rdata_oe_n = st_reg.host_rdata_oe_n;
    assign status_change_out_n = st_reg.status_change_out_n;
    assign rdy_irq_out = st_reg.rdy_irq_out;
    assign card_reset = st_reg.card_reset;
    assign power_down = st_reg.power_down;
    assign mode_memory = st_reg.mode[0];
    assign mode_io_any = st_reg.mode[1];
    assign mode_io_primary = st_reg.mode[2];
    assign mode_io_secondary = st_reg.mode[3];
    assign drive_number = st_reg.drive_number;
    assign cm_read = st_reg.cm_read;
    assign cm_write = st_reg.cm_write;
    assign cm_lanes = st_reg.cm_lanes;
    assign mem_addr = st_reg.mem_addr;
    assign cm_wdata = st_reg.cm_wdata;
    assign cis_read = st_reg.cis_read;
    assign invalid_access = st_reg.invalid_access;

    property p_attr_low_lane;
        @(posedge clk) disable iff (srst) (rd_act && dec.kind != ACC_COMMON) |=> host_rdata_oe_n[1];
    endproperty
    a_attr_low_lane: assert property (p_attr_low_lane) else $error("attribute read drove high lane");

    property p_soft_reset;
        @(posedge clk) disable iff (srst) st_reg.soft_reset_bit |=> card_reset;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not hold card reset");

    property p_hw_clears_soft;
        @(posedge clk) disable iff (srst) pins_i.hw_reset |=> !st_reg.soft_reset_bit;
    endproperty
    a_hw_clears_soft: assert property (p_hw_clears_soft) else $error("soft reset bit survived reset");

    property p_status_change_out_low;
        @(posedge clk) disable iff (srst) (io_mode && st_reg.status_change_enable && changed) |=> !status_change_out_n;
    endproperty
    a_status_change_out_low: assert property (p_status_change_out_low) else $error("status change pin not low");

    property p_status_change_out_high;
        @(posedge clk) disable iff (srst) !st_reg.status_change_enable |=> status_change_out_n;
    endproperty
    a_status_change_out_high: assert property (p_status_change_out_high) else $error("status change pin low while disabled");

    property p_ready_flag;
        @(posedge clk) disable iff (srst || card_rst) (ready_state != $past(ready_state)) |=> st_reg.ready_change_flag;
    endproperty
    a_ready_flag: assert property (p_ready_flag) else $error("ready change not flagged");

    property p_pwr_busy;
        @(posedge clk) disable iff (srst || card_rst)
            (wr_fire && st_reg.cap_dec.kind == ACC_CONFIG && st_reg.cap_addr == OFF_CARD_CONFIG_STATUS
             && wbyte[PWR_DOWN_REQ_POS] != st_reg.power_down_request) |=> (!ready_state ##1 !rdy_irq_out || io_mode);
    endproperty
    a_pwr_busy: assert property (p_pwr_busy) else $error("power change did not report busy");

    property p_level_irq;
        @(posedge clk) disable iff (srst) (io_mode && st_reg.level_irq_select && int_bit) |=> !rdy_irq_out;
    endproperty
    a_level_irq: assert property (p_level_irq) else $error("level interrupt not asserted");

    property p_invalid_no_write;
        @(posedge clk) disable iff (srst || card_rst)
            (wr_fire && st_reg.cap_dec.kind == ACC_INVALID) |=> ($stable(st_reg.config_index) && invalid_access);
    endproperty
    a_invalid_no_write: assert property (p_invalid_no_write) else $error("invalid write changed state");
endmodule

// ===== testbench/cac_host_model.sv
// host socket model: one card bus cycle per call, pins released between cycles
`timescale 1ns/100ps
module cac_host_model (
    // clock
    input wire logic clk,
    // socket pins: attr_n, high_n, low_n, oe_n, we_n
    output logic [4:0] ctl_n,
    output logic [cac_pkg::ADDR_W-1:0] addr,
    output logic [cac_pkg::DATA_W-1:0] wdata,
    // read data settled
    output logic rd_valid
);
    import cac_pkg::*;
    initial begin
        ctl_n = 5'h1F;
        {addr, wdata, rd_valid} = '0;
    end
    task automatic cyc(input logic wr, input logic [2:0] sel_n, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        @(posedge clk);
        ctl_n[4:2] <= sel_n;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        ctl_n[1:0] <= wr ? 2'b10 : 2'b01;
        repeat (6) @(posedge clk);
        rd_valid <= !wr;
        ctl_n[1:0] <= 2'b11;
        @(posedge clk);
        rd_valid <= 1'b0;
        ctl_n[4:2] <= 3'b111;
        // released data lines drift instead of holding the last value
        wdata <= ~wdata;
        repeat (5) @(posedge clk);
    endtask
endmodule

// ===== testbench/cac_regs_test.sv
// self-checking bench for the attribute and configuration register block
`timescale 1ns/100ps
module cac_regs_test;
    import cac_pkg::*;
    logic clk, srst, hw_reset, rb, irq, idis, pdone, rd_valid, inv_seen, lev, sc_n, rdy, crst, pdn, drv, inv;
    logic [4:0] ctl_n;
    logic [3:0] modes;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, cm_rdata;
    logic [BYTE_W-1:0] cis_rdata;
    logic [DATA_W+3:0] exp_q[$];
    logic cmd, idle, cmw, cmr, cisr;
    logic [1:0] oe, cml;
    logic [ADDR_W-1:0] maddr;
    logic [DATA_W-1:0] cwd, cwv;
    logic [ADDR_W+DATA_W+1:0] cm_seen;
    int errors = 0;
    int cmp_count = 0;
    cac_host_model cac_host_model_inst (.clk(clk), .ctl_n(ctl_n), .addr(addr), .wdata(wdata), .rd_valid(rd_valid));
    cac_regs cac_regs_inst (.clk(clk), .srst(srst), .hw_reset(hw_reset), .low_byte_select_n(ctl_n[2]),
        .high_byte_select_n(ctl_n[3]), .attr_select_n(ctl_n[4]), .out_enable_n(ctl_n[1]),
        .write_enable_n(ctl_n[0]), .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata),
        .host_rdata_oe_n(oe), .status_change_out_n(sc_n), .rdy_irq_out(rdy), .ready_busy(rb),
        .irq_request(irq), .irq_disable_bit(idis), .power_done(pdone), .cmd_received(cmd),
        .core_idle(idle), .cm_rdata(cm_rdata), .cis_rdata(cis_rdata), .card_reset(crst),
        .power_down(pdn), .mode_memory(modes[0]), .mode_io_any(modes[1]), .mode_io_primary(modes[2]),
        .mode_io_secondary(modes[3]), .drive_number(drv), .cm_read(cmr), .cm_write(cmw), .cm_lanes(cml),
        .mem_addr(maddr), .cm_wdata(cwd), .cis_read(cisr), .invalid_access(inv));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("errors %0d, comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
        cac_host_model_inst.cyc(1'b1, 3'b010, a, {8'h00, d});
    endtask
    task automatic rd(input logic [2:0] sel_n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        exp_q.push_back({~sel_n[2] & ~a[ATTR_REG_SPACE_POS], sel_n[2], sel_n[2] ? sel_n[1:0] : 2'b10, e});
        cac_host_model_inst.cyc(1'b0, sel_n, a, 16'h0000);
    endtask
    always @(posedge clk) begin
        if (inv === 1'b1) inv_seen <= 1'b1;
        if (cmw === 1'b1) cm_seen <= {cml, maddr, cwd};
        if (rd_valid === 1'b1) begin
            chk("rdata", rdata, exp_q[0][DATA_W-1:0]);
            chk("read_lanes", 16'({cisr, cmr, oe}), 16'(exp_q[0][DATA_W+3:DATA_W]));
            exp_q.delete(0);
        end
    end
    initial begin
        void'($urandom(32'hebca1c12));
        {srst, hw_reset, rb, irq, idis, pdone, inv_seen, cmd, idle} = 9'h140;
        cm_seen = '0;
        cwv = 16'($urandom);
        cm_rdata = 16'($urandom);
        cis_rdata = 8'($urandom);
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        rd(3'b010, OFF_CONFIG_OPTION, 16'h0000);
        rd(3'b000, OFF_PIN_REPLACEMENT, 16'h000E);
        for (int i = 3; i >= 0; i--) begin
            lev = 1'($urandom);
            wr(OFF_CONFIG_OPTION, {1'b0, lev, 6'(i)});
            rd(3'b010, OFF_CONFIG_OPTION, {9'h000, lev, 6'(i)});
            chk("mode", 16'(modes), 16'(1 << i));
        end
        wr(OFF_CARD_CONFIG_STATUS, 8'h64);
        chk("busy", 16'(rdy), 16'h0000);
        chk("power_down", 16'(pdn), 16'h0001);
        pdone <= 1'b1;
        @(posedge clk);
        pdone <= 1'b0;
        repeat (3) @(posedge clk);
        chk("ready", 16'(rdy), 16'h0001);
        irq <= 1'b1;
        rd(3'b010, OFF_CARD_CONFIG_STATUS, 16'h00E6);
        idis <= 1'b1;
        rd(3'b010, OFF_CARD_CONFIG_STATUS, 16'h00E4);
        irq <= 1'b0;
        wr(OFF_PIN_REPLACEMENT, 8'h03);
        wr(OFF_CONFIG_OPTION, 8'h01);
        rb <= 1'b0;
        repeat (4) @(posedge clk);
        rb <= 1'b1;
        rd(3'b010, OFF_CARD_CONFIG_STATUS, 16'h00E4);
        chk("status_change", 16'(sc_n), 16'h0000);
        wr(OFF_PIN_REPLACEMENT, 8'h00);
        rd(3'b010, OFF_PIN_REPLACEMENT, 16'h002E);
        wr(OFF_PIN_REPLACEMENT, 8'h02);
        rd(3'b010, OFF_PIN_REPLACEMENT, 16'h000E);
        chk("status_change", 16'(sc_n), 16'h0001);
        wr(OFF_SOCKET_COPY, 8'h1F);
        rd(3'b010, OFF_SOCKET_COPY, 16'h0010);
        chk("drive", 16'(drv), 16'h0001);
        idis <= 1'b0;
        wr(OFF_CONFIG_OPTION, 8'h41);
        irq <= 1'b1;
        repeat (2) @(posedge clk);
        chk("irq_level", 16'(rdy), 16'h0000);
        irq <= 1'b0;
        wr(OFF_CONFIG_OPTION, 8'h01);
        irq <= 1'b1;
        repeat (3) @(posedge clk);
        chk("irq_pulse", 16'(rdy), 16'h0000);
        repeat (8) @(posedge clk);
        chk("irq_pulse_end", 16'(rdy), 16'h0001);
        irq <= 1'b0;
        wr(OFF_CONFIG_OPTION | 11'h001, 8'h3F);
        wr(11'h000, 8'h3F);
        rd(3'b010, OFF_CONFIG_OPTION, 16'h0001);
        chk("invalid", 16'(inv_seen), 16'h0001);
        rd(3'b010, 11'h000, {8'h00, cis_rdata});
        rd(3'b100, 11'h011, cm_rdata);
        cac_host_model_inst.cyc(1'b1, 3'b100, 11'h011, cwv);
        chk("cm_wdata", cm_seen[DATA_W-1:0], cwv);
        chk("cm_addr", 16'(cm_seen[ADDR_W+DATA_W+1:DATA_W]), 16'({2'b11, 11'h011}));
        wr(OFF_CONFIG_OPTION, 8'h80);
        chk("card_reset", 16'(crst), 16'h0001);
        rd(3'b010, OFF_CONFIG_OPTION, 16'h0080);
        hw_reset <= 1'b1;
        repeat (4) @(posedge clk);
        hw_reset <= 1'b0;
        repeat (4) @(posedge clk);
        rd(3'b010, OFF_CONFIG_OPTION, 16'h0000);
        chk("card_reset", 16'(crst), 16'h0000);
        wr(OFF_CONFIG_OPTION, 8'h80);
        wr(OFF_CONFIG_OPTION, 8'h00);
        chk("card_reset", 16'(crst), 16'h0000);
        idle <= 1'b1;
        repeat (2) @(posedge clk);
        chk("idle_power_down", 16'(pdn), 16'h0001);
        cmd <= 1'b1;
        repeat (2) @(posedge clk);
        chk("command_wake", 16'(pdn), 16'h0000);
        conclude();
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        conclude();
    end
endmodule
